// [pkg/fpc_pkg.sv]
// constants shared by the flash page and sector protect controller
package fpc_pkg;

  // register addresses, 12-bit register file offsets
  localparam logic [11:0] ADDR_CTRL = 12'hff8; // control write, state read
  localparam logic [11:0] ADDR_PAGE = 12'hff9; // page select / sector lock
  localparam logic [11:0] ADDR_TIME_HI = 12'hffa; // timing value high byte
  localparam logic [11:0] ADDR_TIME_LO = 12'hffb; // timing value low byte
  localparam logic [11:0] ADDR_LOCK_RD = 12'hffc; // sector lock readback

  // control register key and command values
  localparam logic [7:0] KEY_FIRST = 8'h73;
  localparam logic [7:0] KEY_SECOND = 8'h8c;
  localparam logic [7:0] KEY_PROTECT = 8'h5e;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;

  // reset values
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [7:0] TIME_RESET = 8'h00;

  // field positions in the page select register
  localparam int INFO_BIT = 7; // information area select
  localparam int PAGE_MSB = 6; // page number field top bit

  // program memory geometry
  localparam int PAGE_SHIFT = 9; // 512-byte pages
  localparam logic [15:0] INFO_BASE = 16'hfe00; // info area window start
  localparam logic [15:0] INFO_LAST = 16'hffff; // info area window end

  // operation lengths in milliseconds; one unit is timing value cycles
  localparam logic [7:0] PROG_UNITS = 8'h01;
  localparam logic [7:0] PAGE_UNITS = 8'h0a;
  localparam logic [7:0] MASS_UNITS = 8'h14;

  // controller state codes as read back from the state code register
  typedef enum logic [5:0] {
    ST_LOCKED = 6'b000000,
    ST_FIRST = 6'b000001,
    ST_SECOND = 6'b000010,
    ST_UNLOCKED = 6'b000011,
    ST_PROT_SEL = 6'b000100,
    ST_PROGRAM = 6'b001000,
    ST_PAGE_ERASE = 6'b010000,
    ST_MASS_ERASE = 6'b100000
  } fpc_state_t;

endpackage

// [verilog/fpc_op_timer.sv]
// operation timer: counts whole milliseconds of system clock
`timescale 1ns/1ps
`default_nettype none
module fpc_op_timer
  import fpc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic start, // one-cycle start pulse
  input wire logic [15:0] cycles_per_unit, // timing value, cycles per ms
  input wire logic [7:0] units, // length of the operation in ms
  // status
  output logic done // one-cycle pulse at the end
);

  logic [15:0] cyc_cnt; // cycles left in the current unit
  logic [7:0] unit_cnt; // units left after the current one
  logic running; // an operation is being timed

  ////////////////////////////////////////////////////////////////////////
  // a timing value of zero is treated as one cycle per unit so that a
  // forgotten load cannot hang the controller forever
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyc_cnt <= 16'h0000;
      unit_cnt <= 8'h00;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        // load the first unit
        running <= 1'b1;
        cyc_cnt <= cycles_per_unit;
        unit_cnt <= (units == 8'h00) ? 8'h00 : units - 8'h01;
      end else if (running) begin
        if (cyc_cnt > 16'h0001) begin
          cyc_cnt <= cyc_cnt - 16'h0001;
        end else if (unit_cnt != 8'h00) begin
          // next millisecond
          cyc_cnt <= cycles_per_unit;
          unit_cnt <= unit_cnt - 8'h01;
        end else begin
          // last cycle of the last unit
          running <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [verilog/fpc_top.sv]
// flash page select, sector lock and unlock sequencer
`timescale 1ns/1ps
`default_nettype none
module fpc_top
  import fpc_pkg::*;
(
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // byte program request from the cpu store path
  input wire logic prog_req,
  input wire logic [15:0] prog_addr,
  // flash array control
  output logic prog_go,
  output logic page_erase_go,
  output logic mass_erase_go,
  output logic [6:0] erase_page,
  output logic flash_busy,
  output logic op_done,
  // configuration seen by the memory map and the array
  output logic info_area_select,
  output logic [7:0] page_select_reg,
  output logic [7:0] sector_lock_bits,
  output logic [15:0] flash_timing_value
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  fpc_state_t state; // controller state, also the readable state code
  fpc_state_t next_state; // state after this cycle
  logic [7:0] flash_timing_high; // upper byte of the timing value
  logic [7:0] flash_timing_low; // lower byte of the timing value
  logic wr_ctrl; // write to the control register
  logic wr_shared; // write to the shared page/lock address
  logic wr_lock; // that write lands in the lock register
  logic wr_time_hi; // write to the timing high byte
  logic wr_time_lo; // write to the timing low byte
  logic page_blocked; // selected page sits in a locked sector
  logic prog_blocked; // addressed byte sits in a locked sector
  logic prog_in_info; // program address falls in the info window
  logic start_prog; // accept a byte program this cycle
  logic start_page; // accept a page erase this cycle
  logic start_mass; // accept a mass erase this cycle
  logic start_any; // any operation starts
  logic [7:0] op_units; // length of the operation being started
  logic timer_done; // pulse from the operation timer
  logic [7:0] next_rdata; // read mux output

  ////////////////////////////////////////////////////////////////////////
  // address decode of writes

  // strobes are single-cycle so the decode needs no holding state
  always_comb begin
    wr_ctrl = 1'b0;
    wr_shared = 1'b0;
    wr_time_hi = 1'b0;
    wr_time_lo = 1'b0;
    if (!reg_wr) begin
      // no write this cycle
      wr_ctrl = 1'b0;
    end else if (reg_addr == ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (reg_addr == ADDR_PAGE) begin
      wr_shared = 1'b1;
    end else if (reg_addr == ADDR_TIME_HI) begin
      wr_time_hi = 1'b1;
    end else if (reg_addr == ADDR_TIME_LO) begin
      wr_time_lo = 1'b1;
    end
  end

  // the shared address only reaches the lock register right after the
  // protect key; in every other state it is the page select register
  assign wr_lock = wr_shared && (state == ST_PROT_SEL);

  ////////////////////////////////////////////////////////////////////////
  // protection checks

  // a 512-byte page number equals the sector number for the low eight
  // pages; pages beyond the lock register are never guarded
  always_comb begin
    page_blocked = 1'b0;
    if (page_select_reg[PAGE_MSB:3] == 4'h0) begin
      page_blocked = sector_lock_bits[page_select_reg[2:0]];
    end
  end

  // the info window is mapped over the top of program memory while the
  // info select bit is set, and it has no sector lock of its own
  assign prog_in_info = info_area_select &&
                        (prog_addr >= INFO_BASE) &&
                        (prog_addr <= INFO_LAST);

  always_comb begin
    prog_blocked = 1'b0;
    if (!prog_in_info && (prog_addr[15:12] == 4'h0)) begin
      // address bits 11:9 pick one of the eight guarded sectors
      prog_blocked = sector_lock_bits[prog_addr[11:PAGE_SHIFT]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation starts

  // operations are only accepted while fully unlocked; a refused one
  // leaves the controller unlocked so software may retry elsewhere
  assign start_prog = (state == ST_UNLOCKED) && prog_req &&
                      !prog_blocked && !reg_wr;
  assign start_page = (state == ST_UNLOCKED) && wr_ctrl &&
                      (reg_wdata == CMD_PAGE_ERASE) && !page_blocked;
  assign start_mass = (state == ST_UNLOCKED) && wr_ctrl &&
                      (reg_wdata == CMD_MASS_ERASE) &&
                      (sector_lock_bits == 8'h00);
  assign start_any = start_prog || start_page || start_mass;

  // operation length picked from the command being started
  always_comb begin
    op_units = PROG_UNITS;
    if (start_page) begin
      op_units = PAGE_UNITS;
    end else if (start_mass) begin
      op_units = MASS_UNITS;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // unlock sequencer

  // control writes during an operation are ignored; the controller
  // cannot be relocked while the array is busy
  always_comb begin
    next_state = state;
    case (state)
      ST_LOCKED: begin
        if (wr_ctrl && (reg_wdata == KEY_FIRST)) begin
          next_state = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (wr_ctrl) begin
          if (reg_wdata == KEY_SECOND) begin
            next_state = ST_SECOND;
          end else if (reg_wdata == KEY_PROTECT) begin
            next_state = ST_PROT_SEL;
          end else if (reg_wdata != KEY_FIRST) begin
            // a repeated first key keeps the sequence open
            next_state = ST_LOCKED;
          end
        end
      end
      ST_SECOND: begin
        // the sequence is complete once the second key lands; the
        // intermediate code is held for one cycle so software can see it
        next_state = ST_UNLOCKED;
      end
      ST_UNLOCKED: begin
        if (start_prog) begin
          next_state = ST_PROGRAM;
        end else if (start_page) begin
          next_state = ST_PAGE_ERASE;
        end else if (start_mass) begin
          next_state = ST_MASS_ERASE;
        end else if (wr_ctrl && (reg_wdata == KEY_FIRST)) begin
          // the first key always opens a new key sequence
          next_state = ST_FIRST;
        end else if (wr_ctrl && (reg_wdata == KEY_PROTECT)) begin
          next_state = ST_PROT_SEL;
        end else if (wr_ctrl && (reg_wdata != CMD_PAGE_ERASE) &&
                     (reg_wdata != CMD_MASS_ERASE)) begin
          next_state = ST_LOCKED;
        end
      end
      ST_PROT_SEL: begin
        if (wr_lock) begin
          // one lock write only, then back to locked
          next_state = ST_LOCKED;
        end else if (wr_ctrl) begin
          next_state = (reg_wdata == KEY_FIRST) ? ST_FIRST : ST_LOCKED;
        end
      end
      ST_PROGRAM, ST_PAGE_ERASE, ST_MASS_ERASE: begin
        if (timer_done) begin
          next_state = ST_UNLOCKED;
        end
      end
      default: begin
        next_state = ST_LOCKED;
      end
    endcase
  end

  // state register; reset leaves the controller locked
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_LOCKED;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // page select register

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      page_select_reg <= PAGE_RESET;
    end else if (wr_shared && !wr_lock) begin
      // default target of the shared address
      page_select_reg <= reg_wdata;
    end
  end

  // info select sits in the top bit of the page select register
  assign info_area_select = page_select_reg[INFO_BIT];

  ////////////////////////////////////////////////////////////////////////
  // sector lock register

  // bits may only be set; nrst is the power-on reset, so a lock stays
  // in force until the part loses power
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sector_lock_bits <= LOCK_RESET;
    end else if (wr_lock) begin
      sector_lock_bits <= sector_lock_bits | reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timing value registers

  // software loads the system clock in kilohertz, which is also the
  // number of cycles in one millisecond used by the timer
  // the array is only specified between 20 kHz and 20 MHz
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_timing_high <= TIME_RESET;
    end else if (wr_time_hi) begin
      flash_timing_high <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_timing_low <= TIME_RESET;
    end else if (wr_time_lo) begin
      flash_timing_low <= reg_wdata;
    end
  end

  // registered copy of the joined value, high byte first
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_timing_value <= {TIME_RESET, TIME_RESET};
    end else begin
      flash_timing_value <= {flash_timing_high, flash_timing_low};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation timer

  // uses the live byte pair so a load just before a start still counts
  fpc_op_timer u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .start(start_any),
    .cycles_per_unit({flash_timing_high, flash_timing_low}),
    .units(op_units),
    .done(timer_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // flash array strobes

  // one-cycle start pulses, and the page number latched for the array
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prog_go <= 1'b0;
      page_erase_go <= 1'b0;
      mass_erase_go <= 1'b0;
      erase_page <= 7'h00;
      op_done <= 1'b0;
    end else begin
      prog_go <= start_prog;
      page_erase_go <= start_page;
      mass_erase_go <= start_mass;
      op_done <= timer_done;
      if (start_page) begin
        // erase every byte whose address bits 15:9 match this page
        erase_page <= page_select_reg[PAGE_MSB:0];
      end
    end
  end

  // busy is registered from next_state, so it changes in the same cycle as the state, like the strobes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flash_busy <= 1'b0;
    end else begin
      flash_busy <= (next_state == ST_PROGRAM) ||
                    (next_state == ST_PAGE_ERASE) ||
                    (next_state == ST_MASS_ERASE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register reads

  // unmapped addresses read zero; the two top bits of the state read
  // are reserved and read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_addr == ADDR_CTRL) begin
      next_rdata = {2'b00, state};
    end else if (reg_addr == ADDR_PAGE) begin
      next_rdata = page_select_reg;
    end else if (reg_addr == ADDR_TIME_HI) begin
      next_rdata = flash_timing_high;
    end else if (reg_addr == ADDR_TIME_LO) begin
      next_rdata = flash_timing_low;
    end else if (reg_addr == ADDR_LOCK_RD) begin
      next_rdata = sector_lock_bits;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// [tb/fpc_top_assertions.sv]
// concurrent checks on the flash page select and sector lock block
`timescale 1ns/1ps
`default_nettype none
module fpc_top_assertions
  import fpc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // byte program request
  input wire logic prog_req,
  input wire logic [15:0] prog_addr,
  // flash array control
  input wire logic prog_go,
  input wire logic page_erase_go,
  input wire logic mass_erase_go,
  input wire logic [6:0] erase_page,
  input wire logic flash_busy,
  input wire logic op_done,
  // configuration
  input wire logic info_area_select,
  input wire logic [7:0] page_select_reg,
  input wire logic [7:0] sector_lock_bits,
  input wire logic [15:0] flash_timing_value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  wire page_wr = reg_wr && reg_addr == ADDR_PAGE; // shared address write
  wire hi_wr = reg_wr && reg_addr == ADDR_TIME_HI;
  wire lo_wr = reg_wr && reg_addr == ADDR_TIME_LO;
  logic [7:0] hi_q; // last high byte written
  logic [7:0] lo_q; // last low byte written
  logic [1:0] quiet; // edges since a timing write, saturating
  // shadow of the timing bytes; quiet lets either output latency pass
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hi_q <= TIME_RESET;
      lo_q <= TIME_RESET;
      quiet <= 2'h3;
    end else begin
      if (hi_wr) hi_q <= reg_wdata;
      if (lo_wr) lo_q <= reg_wdata;
      if (hi_wr || lo_wr) quiet <= 2'h0;
      else if (quiet != 2'h3) quiet <= quiet + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  rdata_idle_a:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  code_width_a:
    assert property ($past(reg_rd && reg_addr == ADDR_CTRL)
      |-> reg_rdata[7:6] == 2'b00)
    else $error("state code wider than six bits");
  info_tie_a:
    assert property (info_area_select == page_select_reg[INFO_BIT])
    else $error("info select differs from page select bit 7");
  lock_sticky_a:
    assert property ((sector_lock_bits & $past(sector_lock_bits))
      == $past(sector_lock_bits))
    else $error("a sector lock bit was cleared");
  page_src_a:
    assert property ($changed(page_select_reg) |-> $past(page_wr))
    else $error("page select changed without a write");
  lock_src_a:
    assert property ($changed(sector_lock_bits) |-> $past(page_wr))
    else $error("sector lock changed without a write");
  timing_pair_a:
    assert property (quiet == 2'h3 |-> flash_timing_value == {hi_q, lo_q})
    else $error("timing value is not high byte then low byte");
  go_busy_a:
    assert property (prog_go || page_erase_go || mass_erase_go
      |-> flash_busy ##1 !(prog_go || page_erase_go || mass_erase_go))
    else $error("go pulse without busy or longer than one cycle");
  erase_page_a:
    assert property (page_erase_go |-> erase_page == page_select_reg[6:0])
    else $error("erase page differs from page field");
  erase_guard_a:
    assert property (page_erase_go |->
      !(erase_page < 7'd8 && sector_lock_bits[erase_page[2:0]]))
    else $error("page erase started on a locked sector");
  mass_guard_a:
    assert property (mass_erase_go |-> sector_lock_bits == 8'h00)
    else $error("mass erase started with a sector locked");
  // main scenarios reached
  cover property (prog_go);
  cover property (page_erase_go);
  cover property (mass_erase_go);
  cover property ($changed(sector_lock_bits));
endmodule
bind fpc_top fpc_top_assertions chk_i (
  .core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .prog_req, .prog_addr, .prog_go, .page_erase_go, .mass_erase_go,
  .erase_page, .flash_busy, .op_done, .info_area_select,
  .page_select_reg, .sector_lock_bits, .flash_timing_value
);
`default_nettype wire

// [tb/fpc_flash_model.sv]
// behavioural flash array: records the byte range of each erase
`timescale 1ns/1ps
`default_nettype none
module fpc_flash_model
  import fpc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // array control from the controller
  input wire logic prog_go,
  input wire logic page_erase_go,
  input wire logic mass_erase_go,
  input wire logic [6:0] erase_page,
  // erased range and accepted operation count
  output logic [15:0] erase_lo,
  output logic [15:0] erase_hi,
  output logic [7:0] op_count
);
  // a page is every byte whose top seven address bits match the page
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      erase_lo <= 16'h0000;
      erase_hi <= 16'h0000;
      op_count <= 8'h00;
    end else begin
      if (page_erase_go) begin
        erase_lo <= {erase_page, 9'h000};
        erase_hi <= {erase_page, 9'h1ff};
      end else if (mass_erase_go) begin
        erase_lo <= 16'h0000; // whole array
        erase_hi <= 16'hffff;
      end
      if (prog_go || page_erase_go || mass_erase_go) op_count <= op_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [tb/fpc_top_test.sv]
// self-checking bench for the flash page select and sector lock block
`timescale 1ns/1ps
`default_nettype none
module fpc_top_test;
  import fpc_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, prog_req;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, page_select_reg, sector_lock_bits;
  logic [15:0] prog_addr, flash_timing_value, erase_lo, erase_hi;
  logic prog_go, page_erase_go, mass_erase_go, flash_busy, op_done;
  logic info_area_select;
  logic [6:0] erase_page;
  logic [7:0] op_count, rv, pg, lk, d;
  int n_fail, n_checks;
  fpc_top dut (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .prog_req, .prog_addr, .prog_go, .page_erase_go,
    .mass_erase_go, .erase_page, .flash_busy, .op_done,
    .info_area_select, .page_select_reg, .sector_lock_bits,
    .flash_timing_value);
  fpc_flash_model arr (.core_clk, .nrst, .prog_go, .page_erase_go,
    .mass_erase_go, .erase_page, .erase_lo, .erase_hi, .op_count);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // lock bits only ever gain ones
  function automatic logic [7:0] f_lock(input logic [7:0] o, n);
    return o | n;
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // bounded wait: 0 for any go pulse, 1 for op_done
  task automatic wait_sig(input int w, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      #1;
      if (w == 0 && (prog_go | page_erase_go | mass_erase_go) === 1'b1) break;
      if (w == 1 && op_done === 1'b1) break;
      @(posedge core_clk);
    end
    if (i == lim) begin
      n_fail++;
      $display("BAD wait_%0d expected 1 seen 0", w);
      summarize();
    end
  endtask
  task automatic unlock();
    wr(ADDR_CTRL, KEY_FIRST);
    wr(ADDR_CTRL, KEY_SECOND);
  endtask
  // command 00 stands for a byte program request
  task automatic start(input logic [7:0] c);
    if (c != 8'h00) wr(ADDR_CTRL, c);
    else begin
      @(posedge core_clk);
      prog_req <= 1'b1;
      @(posedge core_clk);
      prog_req <= 1'b0;
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [5:0] st);
    start(c);
    wait_sig(0, 8);
    chk("busy", 1'b1, flash_busy);
    if (c == CMD_PAGE_ERASE) chk("erase_page", pg[6:0], erase_page);
    rd(ADDR_CTRL, rv);
    chk("busy_code", st, rv);
    wait_sig(1, 1000);
    rd(ADDR_CTRL, rv);
    chk("after_op", ST_UNLOCKED, rv);
  endtask
  task automatic refuse(input logic [7:0] c);
    start(c);
    repeat (4) @(posedge core_clk);
    #1 chk("refused", 1'b0, flash_busy);
    rd(ADDR_CTRL, rv);
    chk("refused_code", ST_UNLOCKED, rv);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    prog_req = 1'b0;
    prog_addr = 16'h0000;
    n_fail = 0;
    n_checks = 0;
    rv = 8'($urandom(32'h7ff4));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rd(ADDR_PAGE, rv);
    chk("page_reset", PAGE_RESET, rv);
    rd(ADDR_LOCK_RD, rv);
    chk("lock_reset", LOCK_RESET, rv);
    rd(ADDR_CTRL, rv);
    chk("state_reset", ST_LOCKED, rv);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      pg = (i < 2) ? {i[0], 7'h7f} : 8'($urandom);
      wr(ADDR_PAGE, pg);
      rd(ADDR_PAGE, rv);
      chk("page_rd", pg, rv);
      chk("info_sel", pg[INFO_BIT], info_area_select);
    end
    $display("test page select done");
    // i == 2 loads the 10 MHz bench clock in kHz; i == 3 then loads a
    // short value so that erases fit the cycle budget of the run
    for (int i = 0; i < 4; i++) begin
      pg = (i == 2) ? 8'h27 : (i == 3) ? 8'h00 : 8'($urandom);
      d = (i == 2) ? 8'h10 : (i == 3) ? 8'h10 : 8'($urandom);
      wr(ADDR_TIME_HI, pg);
      wr(ADDR_TIME_LO, d);
      repeat (2) @(posedge core_clk);
      #1 chk("timing", {pg, d}, flash_timing_value);
    end
    $display("test timing done");
    wr(ADDR_CTRL, KEY_FIRST);
    rd(ADDR_CTRL, rv);
    chk("state_first", ST_FIRST, rv);
    wr(ADDR_CTRL, 8'h11);
    rd(ADDR_CTRL, rv);
    chk("bad_key", ST_LOCKED, rv);
    unlock();
    rd(ADDR_CTRL, rv);
    chk("unlocked", ST_UNLOCKED, rv);
    wr(ADDR_CTRL, 8'h11);
    rd(ADDR_CTRL, rv);
    chk("relock", ST_LOCKED, rv);
    $display("test keys done");
    unlock();
    prog_addr <= 16'($urandom) & 16'h0fff;
    op(8'h00, ST_PROGRAM);
    op(CMD_MASS_ERASE, ST_MASS_ERASE);
    pg = {5'h00, 3'($urandom)};
    wr(ADDR_PAGE, pg);
    op(CMD_PAGE_ERASE, ST_PAGE_ERASE);
    chk("erase_lo", {pg[6:0], 9'h000}, erase_lo);
    chk("erase_hi", {pg[6:0], 9'h1ff}, erase_hi);
    $display("test operations done");
    lk = LOCK_RESET;
    for (int i = 0; i < 3; i++) begin
      d = (i == 1) ? 8'h00 : (8'($urandom) | 8'h01);
      if (i == 1) unlock();
      else wr(ADDR_CTRL, KEY_FIRST);
      wr(ADDR_CTRL, KEY_PROTECT);
      rd(ADDR_CTRL, rv);
      chk("prot_sel", ST_PROT_SEL, rv);
      wr(ADDR_PAGE, d);
      lk = f_lock(lk, d);
      rd(ADDR_LOCK_RD, rv);
      chk("lock", lk, rv);
      chk("page_kept", pg, page_select_reg);
      wr(ADDR_PAGE, ~d);
      #1 chk("lock_kept", lk, sector_lock_bits);
      pg = ~d;
    end
    $display("test sector lock done");
    wr(ADDR_PAGE, 8'h00);
    unlock();
    refuse(CMD_PAGE_ERASE);
    refuse(CMD_MASS_ERASE);
    prog_addr <= 16'h0010;
    refuse(8'h00);
    pg = 8'h08;
    wr(ADDR_PAGE, pg);
    op(CMD_PAGE_ERASE, ST_PAGE_ERASE);
    chk("erase_lo8", {pg[6:0], 9'h000}, erase_lo);
    chk("op_count", 8'h04, op_count);
    $display("test refusals done");
    summarize();
  end
endmodule
`default_nettype wire
